// ### hdl/sector_protect_regs.svh
// Constants for the sector write-protection block: opcodes, map layout and timing.
`ifndef SECTOR_PROTECT_REGS_SVH
`define SECTOR_PROTECT_REGS_SVH

`define OP_PREFIX0          8'h3D
`define OP_PREFIX1          8'h2A
`define OP_PREFIX2          8'h7F
`define OP_PROT_ENABLE      8'hA9
`define OP_PROT_DISABLE     8'h9A
`define OP_MAP_ERASE        8'hCF
`define MAP_ERASED_BYTE     8'hFF
`define MAP_SHIPPED_BYTE    8'h00
`define MAP_BYTES           8
`define SUB0A_HI            7
`define SUB0A_LO            6
`define SUB0B_HI            5
`define SUB0B_LO            4
`define SUB0B_FIRST_PAGE    8
`define WP_FILTER_CYCLES    4
`define MAP_ERASE_TIME_US   2000
`define MCLK_MHZ            25
`define MAP_ERASE_CYCLES    (`MAP_ERASE_TIME_US * `MCLK_MHZ)

`endif

// ### hdl/sector_protect_pkg.sv
// Types shared by the sector write-protection block.
package sector_protect_pkg;

    // Command decoded on the serial link, carried to the core clock.
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_ENABLE,
        CMD_DISABLE,
        CMD_ERASE
    } link_cmd_t;

    // A program or erase request from the array controller.
    typedef struct packed {
        logic       valid;
        logic [2:0] sector;
        logic [3:0] page;
        logic       is_map;
    } pe_req_t;

    // Verdict on that request.
    typedef struct packed {
        logic allow;
        logic block;
    } pe_ans_t;

endpackage : sector_protect_pkg

// ### hdl/spi_cmd_shifter.sv
// Serial-clock command shifter that recognises the three protection commands.
`timescale 1ns/10ps
`default_nettype none
module spi_cmd_shifter (
    // Core reset, which also clears the captured command.
    input  wire logic                          rst_b,
    // Serial link.
    input  wire logic                          sclk,
    input  wire logic                          cs_b,
    input  wire logic                          si,
    // Recognised command, held until the next frame and flagged by a toggle.
    output var  sector_protect_pkg::link_cmd_t cmd,
    output logic                               cmd_tgl
);
`include "sector_protect_regs.svh"

    logic [31:0]                   shift_q,  shift_d;
    logic [5:0]                    count_q,  count_d;
    sector_protect_pkg::link_cmd_t cmd_q,    cmd_d;
    logic                          tgl_q,    tgl_d;

    // Decodes the four opcode bytes; anything but exactly 32 bits is no command.
    function automatic sector_protect_pkg::link_cmd_t decode(input logic [31:0] w);
        if (w[31:8] != {`OP_PREFIX0, `OP_PREFIX1, `OP_PREFIX2}) begin
            return sector_protect_pkg::CMD_NONE;
        end
        case (w[7:0])
            `OP_PROT_ENABLE:  return sector_protect_pkg::CMD_ENABLE;
            `OP_PROT_DISABLE: return sector_protect_pkg::CMD_DISABLE;
            `OP_MAP_ERASE:    return sector_protect_pkg::CMD_ERASE;
            default:          return sector_protect_pkg::CMD_NONE;
        endcase
    endfunction : decode

    // Bits shift in on rising sclk while chip select is low; the frame is
    // judged on the rising edge of chip select, which ends it without sclk.
    always_comb begin
        shift_d = {shift_q[30:0], si};
        count_d = (count_q == 6'h3F) ? count_q : count_q + 6'h01;
    end

    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            shift_q <= 32'h0000_0000;
            count_q <= 6'h00;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // Command latched when chip select rises after exactly 32 bits.
    always_comb begin
        cmd_d = (count_q == 6'h20) ? decode(shift_q) : sector_protect_pkg::CMD_NONE;
        tgl_d = (cmd_d != sector_protect_pkg::CMD_NONE) ? ~tgl_q : tgl_q;
    end

    // The edge of cs_b is the clock here; the core reset gives the toggle a
    // known start, so the core does not see a false command after reset.
    always_ff @(posedge cs_b or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= sector_protect_pkg::CMD_NONE;
            tgl_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            tgl_q <= tgl_d;
        end
    end

    assign cmd     = cmd_q;
    assign cmd_tgl = tgl_q;

endmodule : spi_cmd_shifter
`default_nettype wire

// ### hdl/wp_filter.sv
// Glitch filter for the write-protect pin, after a three-stage synchroniser.
`timescale 1ns/10ps
`default_nettype none
`include "sector_protect_regs.svh"
module wp_filter #(
    parameter int unsigned FILTER_CYCLES = `WP_FILTER_CYCLES
) (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_b,
    // Raw pin and filtered level.
    input  wire logic wp_b,
    output logic      wp_asserted
);

    logic [2:0] sync_q,  sync_d;
    logic [7:0] run_q,   run_d;
    logic       level_q, level_d;

    // The first stage feeds only the second; stages two and three must agree.
    always_comb begin
        sync_d  = {sync_q[1:0], wp_b};
        run_d   = run_q;
        level_d = level_q;
        if (sync_q[1] != sync_q[2] || (~sync_q[2]) == level_q) begin
            run_d = 8'h00;
        end else if (run_q == 8'(FILTER_CYCLES - 1)) begin
            run_d   = 8'h00;
            level_d = ~sync_q[2];
        end else begin
            run_d = run_q + 8'h01;
        end
    end

    // Pin idles high, so the synchroniser resets to deasserted.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q  <= 3'b111;
            run_q   <= 8'h00;
            level_q <= 1'b0;
        end else begin
            sync_q  <= sync_d;
            run_q   <= run_d;
            level_q <= level_d;
        end
    end

    assign wp_asserted = level_q;

    // A pulse of one sample on stage three never changes the level.
    property p_wp_filter_stable;
        @(posedge mclk) disable iff (!rst_b)
        $changed(level_q) |-> $past(sync_q[2]) == $past(sync_q[2], 2);
    endproperty
    a_wp_filter_stable: assert property (p_wp_filter_stable)
        else $error("Filtered write-protect changed without a stable input.");

endmodule : wp_filter
`default_nettype wire

// ### hdl/sector_write_protection.sv
// Sector write-protection core: effective protection, map, map erase and verdicts.
`timescale 1ns/10ps
`default_nettype none
`include "sector_protect_regs.svh"
module sector_write_protection #(
    parameter int unsigned ERASE_CYCLES = `MAP_ERASE_CYCLES
) (
    // Core clock and reset.
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    // Serial link.
    input  wire logic                          sclk,
    input  wire logic                          cs_b,
    input  wire logic                          si,
    // Write-protect pin, active low.
    input  wire logic                          wp_b,
    // Program or erase request from the array controller.
    input  wire sector_protect_pkg::pe_req_t   pe_req,
    output var  sector_protect_pkg::pe_ans_t   pe_ans,
    // Map program port; a write only clears bits of an erased map.
    input  wire logic                          map_wr,
    input  wire logic [2:0]                    map_wr_idx,
    input  wire logic [7:0]                    map_wr_data,
    // Status.
    output logic                               ready,
    output logic                               prot_on,
    output logic                               wp_active,
    output logic [63:0]                        map_bytes
);

    localparam int unsigned NBYTES = `MAP_BYTES;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ERASE
    } erase_state_t;

    sector_protect_pkg::link_cmd_t link_cmd;
    logic                          link_tgl;
    logic [2:0]                    tgl_sync_q, tgl_sync_d;
    logic                          cmd_ev;
    logic                          wp_on;
    logic                          sw_en_q,  sw_en_d;
    logic [7:0]                    map_q [NBYTES];
    logic [7:0]                    map_d [NBYTES];
    erase_state_t                  st_q,     st_d;
    logic [31:0]                   cnt_q,    cnt_d;
    sector_protect_pkg::pe_ans_t   ans_q,    ans_d;
    logic                          eff_on;

    // Command recogniser lives on the serial clock.
    spi_cmd_shifter u_shifter (
        .rst_b   (rst_b),
        .sclk    (sclk),
        .cs_b    (cs_b),
        .si      (si),
        .cmd     (link_cmd),
        .cmd_tgl (link_tgl)
    );

    // Filtered write-protect level.
    wp_filter u_wp (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .wp_b        (wp_b),
        .wp_asserted (wp_on)
    );

    // Toggle crossing: the command word is stable long before its toggle lands.
    always_comb begin
        tgl_sync_d = {tgl_sync_q[1:0], link_tgl};
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_sync_q <= 3'b000;
        end else begin
            tgl_sync_q <= tgl_sync_d;
        end
    end

    assign cmd_ev = tgl_sync_q[2] != tgl_sync_q[1];

    // Is a given target page guarded by the map?
    function automatic logic guarded(input logic [7:0] b, input logic [2:0] s,
                                     input logic [3:0] pg);
        if (s != 3'h0) begin
            return b == `MAP_ERASED_BYTE;
        end
        if (pg < 4'(`SUB0B_FIRST_PAGE)) begin
            return b[`SUB0A_HI:`SUB0A_LO] == 2'b11;
        end
        return b[`SUB0B_HI:`SUB0B_LO] == 2'b11;
    endfunction : guarded

    // Software enable; a disable under the pin is dropped, never queued for later.
    always_comb begin
        sw_en_d = sw_en_q;
        if (cmd_ev && link_cmd == sector_protect_pkg::CMD_ENABLE) begin
            sw_en_d = 1'b1;
        end else if (cmd_ev && link_cmd == sector_protect_pkg::CMD_DISABLE && !wp_on) begin
            sw_en_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sw_en_q <= 1'b0;
        end else begin
            sw_en_q <= sw_en_d;
        end
    end

    // Pin forces protection on; release falls back to the software state.
    assign eff_on = wp_on | sw_en_q;

    // Map erase engine; erase is taken whatever the software enable, but never while the pin is asserted.
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        for (int i = 0; i < NBYTES; i++) begin
            map_d[i] = map_q[i];
        end
        case (st_q)
            ST_IDLE: begin
                if (cmd_ev && link_cmd == sector_protect_pkg::CMD_ERASE && !wp_on) begin
                    st_d  = ST_ERASE;
                    cnt_d = 32'h0000_0000;
                end else if (map_wr && !wp_on) begin
                    map_d[map_wr_idx] = map_q[map_wr_idx] & map_wr_data;
                end
            end
            ST_ERASE: begin
                if (cnt_q == 32'(ERASE_CYCLES - 1)) begin
                    st_d = ST_IDLE;
                    for (int i = 0; i < NBYTES; i++) begin
                        map_d[i] = `MAP_ERASED_BYTE;
                    end
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Map starts at its shipped value; no nonvolatile storage is modelled.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q  <= ST_IDLE;
            cnt_q <= 32'h0000_0000;
            for (int i = 0; i < NBYTES; i++) begin
                map_q[i] <= `MAP_SHIPPED_BYTE;
            end
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            for (int i = 0; i < NBYTES; i++) begin
                map_q[i] <= map_d[i];
            end
        end
    end

    // Registered verdict one cycle after the request.
    always_comb begin
        ans_d = '0;
        if (pe_req.valid) begin
            if (pe_req.is_map) begin
                ans_d.block = wp_on || st_q == ST_ERASE;
            end else begin
                ans_d.block = st_q == ST_ERASE ||
                    (eff_on && guarded(map_q[pe_req.sector], pe_req.sector, pe_req.page));
            end
            ans_d.allow = ~ans_d.block;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ans_q <= '0;
        end else begin
            ans_q <= ans_d;
        end
    end

    // Status outputs.
    assign pe_ans    = ans_q;
    assign ready     = st_q == ST_IDLE;
    assign prot_on   = eff_on;
    assign wp_active = wp_on;
    always_comb begin
        for (int i = 0; i < NBYTES; i++) begin
            map_bytes[i*8 +: 8] = map_q[i];
        end
    end

    // Length of the current busy stretch; a counter, since the erase time is far
    // too long for a repetition in a property.
    logic [31:0] busy_len_q, busy_len_d;

    always_comb begin
        busy_len_d = ready ? 32'h0000_0000 : busy_len_q + 32'h0000_0001;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy_len_q <= 32'h0000_0000;
        end else begin
            busy_len_q <= busy_len_d;
        end
    end

    // Busy lasts exactly the erase time after a taken erase.
    sequence s_erase_start;
        st_q == ST_IDLE ##1 st_q == ST_ERASE;
    endsequence
    sequence s_erase_done;
        !ready ##1 ready;
    endsequence
    property p_erase_busy;
        @(posedge mclk) disable iff (!rst_b)
        s_erase_done |-> busy_len_q == 32'(ERASE_CYCLES);
    endproperty
    a_erase_busy: assert property (p_erase_busy)
        else $error("Busy did not last the map erase time.");

    property p_erase_ends;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == ST_ERASE && cnt_q == 32'(ERASE_CYCLES - 1)) |=> ready && map_q[0] == 8'hFF;
    endproperty
    a_erase_ends: assert property (p_erase_ends)
        else $error("Map erase did not finish with an erased map.");

    property p_disable_ignored;
        @(posedge mclk) disable iff (!rst_b)
        (cmd_ev && link_cmd == sector_protect_pkg::CMD_DISABLE && wp_on && sw_en_q) |=> sw_en_q;
    endproperty
    a_disable_ignored: assert property (p_disable_ignored)
        else $error("Disable command acted while write-protect asserted.");

    // Eight samples cover three synchroniser stages, the four-cycle filter and
    // the level register; a longer filter needs a longer window here.
    property p_wp_forces;
        @(posedge mclk) disable iff (!rst_b)
        (!wp_b) [*8] |-> prot_on && wp_active;
    endproperty
    a_wp_forces: assert property (p_wp_forces)
        else $error("Protection off while write-protect asserted.");

    property p_release_off;
        @(posedge mclk) disable iff (!rst_b)
        (wp_b [*8] ##0 !sw_en_q) |-> !prot_on && !wp_active;
    endproperty
    a_release_off: assert property (p_release_off)
        else $error("Protection stayed on after release without enable.");

    property p_map_locked;
        @(posedge mclk) disable iff (!rst_b)
        (wp_on && st_q == ST_IDLE) |=> $stable(map_bytes) && st_q == ST_IDLE;
    endproperty
    a_map_locked: assert property (p_map_locked)
        else $error("Map changed while write-protect asserted.");

    property p_block_erased;
        @(posedge mclk) disable iff (!rst_b)
        (pe_req.valid && !pe_req.is_map && eff_on && map_q[pe_req.sector] == 8'hFF)
            |=> pe_ans.block && !pe_ans.allow;
    endproperty
    a_block_erased: assert property (p_block_erased)
        else $error("Request to an erased-map sector was not blocked.");

    property p_reset_clear;
        @(posedge mclk) $rose(rst_b) |-> !sw_en_q && map_q[7] == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Protection state not cleared after reset.");

    property p_erase_taken;
        @(posedge mclk) disable iff (!rst_b)
        (cmd_ev && link_cmd == sector_protect_pkg::CMD_ERASE && !wp_on && ready)
            |-> s_erase_start;
    endproperty
    a_erase_taken: assert property (p_erase_taken)
        else $error("Map erase command was not taken.");

    property p_sticky_enable;
        @(posedge mclk) disable iff (!rst_b)
        (sw_en_q && !(cmd_ev && link_cmd == sector_protect_pkg::CMD_DISABLE))
            |=> sw_en_q && prot_on;
    endproperty
    a_sticky_enable: assert property (p_sticky_enable)
        else $error("Software protection dropped without a disable command.");

endmodule : sector_write_protection
`default_nettype wire

// ### sim/spi_host_model.sv
// Behavioural serial host that clocks protection commands in and drives the pin.
`timescale 1ns/10ps
`default_nettype none
`include "sector_protect_regs.svh"
module spi_host_model (
    // Serial link.
    output var logic sclk,
    output var logic cs_b,
    output var logic si,
    // Write-protect pin, active low.
    output var logic wp_b
);
    // Idle link: clock parked low, chip select high, pin at its pull-up level.
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        si   = 1'b0;
        wp_b = 1'b1;
    end

    // Prefix bytes then the final opcode, MSB first, 12 ns per bit.
    task automatic send_cmd(input logic [7:0] op);
        logic [31:0] frame;
        frame = {`OP_PREFIX0, `OP_PREFIX1, `OP_PREFIX2, op};
        cs_b = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            si = frame[i];
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
        end
        #6 cs_b = 1'b1;
        // A released data line flips so a stale bit never looks valid.
        si = ~si;
    endtask : send_cmd

    // The bench moves the pin just after a core clock edge, except for the release right after a command frame in t_sticky.
    task automatic set_wp(input logic level);
        wp_b = level;
    endtask : set_wp
endmodule : spi_host_model
`default_nettype wire

// ### sim/sector_write_protection_tb.sv
// Self-checking bench for the sector write-protection core.
`timescale 1ns/10ps
`default_nettype none
`include "sector_protect_regs.svh"
module sector_write_protection_tb;
    // Short erase so the run stays brief.
    localparam int unsigned EC = 20;
    logic                        mclk, rst_b, sclk, cs_b, si, wp_b;
    logic                        map_wr, ready, prot_on, wp_active;
    logic [2:0]                  map_wr_idx;
    logic [7:0]                  map_wr_data;
    logic [63:0]                 map_bytes;
    sector_protect_pkg::pe_req_t pe_req;
    sector_protect_pkg::pe_ans_t pe_ans;
    int                          n_mismatch, checks;

    sector_write_protection #(.ERASE_CYCLES(EC)) i_sector_write_protection (
        .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si), .wp_b(wp_b),
        .pe_req(pe_req), .pe_ans(pe_ans), .map_wr(map_wr), .map_wr_idx(map_wr_idx),
        .map_wr_data(map_wr_data), .ready(ready), .prot_on(prot_on),
        .wp_active(wp_active), .map_bytes(map_bytes));
    spi_host_model i_spi_host_model (.sclk(sclk), .cs_b(cs_b), .si(si), .wp_b(wp_b));

    // Core clock, 40 ns period.
    always #20 mclk = ~mclk;

    // Inputs move one nanosecond after the edge so no race with sampling.
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // Bounded wait on the protection flag; a miss ends the run.
    task automatic wait_prot(input logic v);
        int n;
        n = 0;
        while (prot_on !== v && n < 12) begin
            tick();
            n++;
        end
        check(prot_on, v, "prot_on level");
        if (prot_on !== v) report_and_stop();
    endtask : wait_prot

    // One-cycle request; the verdict stands in the following cycle only.
    task automatic req(input logic [2:0] sec, input logic [3:0] pg, input logic mp,
                       input logic blk);
        tick();
        pe_req = {1'b1, sec, pg, mp};
        tick();
        pe_req = '0;
        check({pe_ans.allow, pe_ans.block}, {~blk, blk}, "verdict");
    endtask : req

    task automatic write_map(input logic [2:0] idx, input logic [7:0] d);
        tick();
        map_wr      = 1'b1;
        map_wr_idx  = idx;
        map_wr_data = d;
        tick();
        map_wr = 1'b0;
        tick();
    endtask : write_map

    // Erase must wait for chip select, then hold busy for the erase time.
    task automatic erase_map;
        int n;
        n = 0;
        i_spi_host_model.send_cmd(`OP_MAP_ERASE);
        check(ready, 1'b1, "busy before chip select rose");
        while (ready !== 1'b0 && n < 12) begin
            tick();
            n++;
        end
        check(ready, 1'b0, "erase started");
        if (ready !== 1'b0) report_and_stop();
        n = 0;
        while (ready === 1'b0 && n < 200) begin
            tick();
            n++;
        end
        check(n, EC, "erase length");
        check(map_bytes, {8{`MAP_ERASED_BYTE}}, "erased map");
    endtask : erase_map

    task automatic t_reset;
        check({ready, prot_on, wp_active}, 3'h4, "idle flags");
        check(map_bytes, 64'h0, "shipped map");
        req(3'h3, 4'h0, 1'b0, 1'b0);
        $display("test reset done");
    endtask : t_reset

    // Glitch, pin assertion, ignored disable, then release.
    task automatic t_pin;
        logic seen;
        seen = 1'b0;
        i_spi_host_model.set_wp(1'b0);
        tick();
        tick();
        i_spi_host_model.set_wp(1'b1);
        repeat (12) begin
            tick();
            seen = seen | wp_active;
        end
        check(seen, 1'b0, "glitch passed filter");
        i_spi_host_model.set_wp(1'b0);
        wait_prot(1'b1);
        check(wp_active, 1'b1, "pin seen");
        i_spi_host_model.send_cmd(`OP_PROT_DISABLE);
        repeat (10) tick();
        check(prot_on, 1'b1, "disable under pin");
        i_spi_host_model.set_wp(1'b1);
        wait_prot(1'b0);
        $display("test pin done");
    endtask : t_pin

    // Enable issued while the pin is low keeps protection after release.
    task automatic t_sticky;
        i_spi_host_model.set_wp(1'b0);
        wait_prot(1'b1);
        i_spi_host_model.send_cmd(`OP_PROT_ENABLE);
        tick();
        i_spi_host_model.send_cmd(`OP_PROT_DISABLE);
        i_spi_host_model.set_wp(1'b1);
        repeat (14) tick();
        check(prot_on, 1'b1, "protection held");
        i_spi_host_model.send_cmd(`OP_PROT_DISABLE);
        wait_prot(1'b0);
        i_spi_host_model.send_cmd(`OP_PROT_ENABLE);
        wait_prot(1'b1);
        $display("test sticky done");
    endtask : t_sticky

    task automatic t_erase;
        erase_map();
        for (int s = 0; s < 8; s++) begin
            req(s[2:0], 4'h0, 1'b0, 1'b1);
        end
        req(3'h0, 4'h9, 1'b0, 1'b1);
        $display("test erase done");
    endtask : t_erase

    // Unprotect sector 1 and the lower half of sector 0.
    task automatic t_program;
        write_map(3'h1, 8'h00);
        write_map(3'h0, 8'h3F);
        check(map_bytes[15:0], 16'h003F, "programmed bytes");
        write_map(3'h1, 8'hFF);
        check(map_bytes[15:8], 8'h00, "rewrite without erase");
        req(3'h1, 4'h0, 1'b0, 1'b0);
        req(3'h2, 4'h0, 1'b0, 1'b1);
        req(3'h0, 4'h7, 1'b0, 1'b0);
        req(3'h0, 4'h8, 1'b0, 1'b1);
        $display("test program done");
    endtask : t_program

    // Pin asserted: map writes, map erase and protected sectors are refused.
    task automatic t_lock;
        logic seen;
        seen = 1'b0;
        i_spi_host_model.set_wp(1'b0);
        repeat (12) tick();
        write_map(3'h2, 8'h00);
        check(map_bytes[23:16], 8'hFF, "map write under pin");
        req(3'h2, 4'h0, 1'b1, 1'b1);
        req(3'h2, 4'h0, 1'b0, 1'b1);
        req(3'h1, 4'h0, 1'b0, 1'b0);
        i_spi_host_model.send_cmd(`OP_MAP_ERASE);
        repeat (10) begin
            tick();
            seen = seen | ~ready;
        end
        check(seen, 1'b0, "erase under pin");
        i_spi_host_model.set_wp(1'b1);
        repeat (12) tick();
        $display("test lock done");
    endtask : t_lock

    task automatic t_off;
        i_spi_host_model.send_cmd(`OP_PROT_DISABLE);
        wait_prot(1'b0);
        req(3'h2, 4'h0, 1'b0, 1'b0);
        req(3'h0, 4'h9, 1'b0, 1'b0);
        erase_map();
        $display("test off done");
    endtask : t_off

    // Main sequence.
    initial begin
        mclk        = 1'b0;
        rst_b       = 1'b0;
        pe_req      = '0;
        map_wr      = 1'b0;
        map_wr_idx  = 3'h0;
        map_wr_data = 8'h00;
        n_mismatch  = 0;
        checks      = 0;
        repeat (10) @(posedge mclk);
        #1 rst_b = 1'b1;
        t_reset();
        t_pin();
        t_sticky();
        t_erase();
        t_program();
        t_lock();
        t_off();
        report_and_stop();
    end
endmodule : sector_write_protection_tb
`default_nettype wire
